//--- logic/dcd_device.sv
// Device end: registers command pins each rising edge and decodes them.
// Assumes the controller keeps the link rules and drives pins on core_clk.
// Device reset pin and rstn both clear all state.
`timescale 1ns/1ps
module dcd_device
  import dcd_pkg::*;
#(
  parameter int BA_W   = DCD_BA_W,
  parameter int ADDR_W = DCD_ADDR_W
) (
  input  wire logic              core_clk,   // Clock
  input  wire logic              rstn,       // Async reset, active low
  dcd_if.dev                     pins,       // Command pins
  input  wire logic              fixed_bl,   // Burst length fixed by MRS
  input  wire logic              fixed_bc4,  // Fixed mode chops to 4
  output dcd_pkg::dcd_cmd_t      cmd,        // Decoded command
  output logic [BA_W-1:0]        cmd_ba,     // Latched bank address
  output logic [ADDR_W-1:0]      cmd_addr,   // Latched address
  output logic                   cmd_bc4,    // Burst chop of 4
  output logic                   burst_busy, // Burst in progress
  output logic                   in_pdn,     // Powered down
  output logic                   in_sref,    // In self refresh
  output logic                   odt_ok      // Termination available
);
  import dcd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              cke_prev;
    dcd_pwr_t          pwr;
    dcd_cmd_t          cmd;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic              bc4;
    logic [2:0]        bcnt;
  } dcd_st_t;

  dcd_st_t st_ff;
  dcd_st_t nxt_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // NOP or deselect
  function automatic logic is_nop(input logic [3:0] p);
    return p[3] || p == DCD_PAT_NOP;
  endfunction

  // Command reported while a low-power state is kept
  function automatic dcd_cmd_t idle_cmd(input logic [3:0] p);
    return p[3] ? DCD_DES : DCD_NOP;
  endfunction

  // Clock enable rising with NOP or deselect leaves low power
  function automatic logic pwr_exit(input logic       ck_prev,
                                    input logic       ck,
                                    input logic [3:0] p);
    return !ck_prev && ck && is_nop(p);
  endfunction

  // Read or write, with or without auto-precharge
  function automatic dcd_cmd_t rdwr_cmd(input logic rd,
                                        input logic ap);
    if (rd) begin
      return ap ? DCD_RDA : DCD_RD;
    end
    return ap ? DCD_WRA : DCD_WR;
  endfunction

  // Clock cycles of one burst
  function automatic logic [2:0] burst_cyc(input logic chop);
    return chop ? 3'(DCD_BC4_CYC) : 3'(DCD_BL8_CYC);
  endfunction

  // ----------------------------------------------------------------
  // Reset: system reset or the controller's reset pin
  // ----------------------------------------------------------------
  logic dev_rstn;

  assign dev_rstn = rstn & pins.reset_n;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] pat;
    logic       ap;
    logic       chop;
    pat    = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    ap     = pins.addr[DCD_AP_BIT];
    chop   = fixed_bl ? fixed_bc4 : ~pins.addr[DCD_BC_BIT];
    nxt_st = st_ff;
    nxt_st.cke_prev = pins.cke;
    nxt_st.ba   = pins.ba;
    nxt_st.addr = pins.addr;
    nxt_st.cmd  = DCD_ILLEGAL;
    // Burst counter
    if (st_ff.bcnt != 3'h0) begin
      nxt_st.bcnt = st_ff.bcnt - 3'h1;
    end
    // Power state and command
    case (st_ff.pwr)
      DCD_ST_SREF: begin
        if (pwr_exit(st_ff.cke_prev, pins.cke, pat)) begin
          nxt_st.cmd = DCD_SRX;
          nxt_st.pwr = DCD_ST_IDLE;
        end else if (!pins.cke) begin
          nxt_st.cmd = idle_cmd(pat);
        end
      end
      DCD_ST_PDN: begin
        if (pwr_exit(st_ff.cke_prev, pins.cke, pat)) begin
          nxt_st.cmd = DCD_PDX;
          nxt_st.pwr = DCD_ST_IDLE;
        end else if (!pins.cke) begin
          nxt_st.cmd = idle_cmd(pat);
        end
      end
      default: begin
        if (!pins.cke) begin
          if (is_nop(pat)) begin
            nxt_st.cmd = DCD_PDE;
            nxt_st.pwr = DCD_ST_PDN;
          end else if (pat == DCD_PAT_REF && st_ff.bcnt == 3'h0) begin
            nxt_st.cmd = DCD_SRE;
            nxt_st.pwr = DCD_ST_SREF;
          end
        end else if (pat[3]) begin
          nxt_st.cmd = DCD_DES;
        end else begin
          case (pat)
            DCD_PAT_MRS: nxt_st.cmd = DCD_MRS;
            DCD_PAT_REF: nxt_st.cmd = DCD_REF;
            DCD_PAT_PRE: nxt_st.cmd = ap ? DCD_PREA : DCD_PRE;
            DCD_PAT_ACT: nxt_st.cmd = DCD_ACT;
            DCD_PAT_ZQ:  nxt_st.cmd = ap ? DCD_ZQCL : DCD_ZQCS;
            DCD_PAT_NOP: nxt_st.cmd = DCD_NOP;
            DCD_PAT_WR, DCD_PAT_RD: begin
              nxt_st.cmd = rdwr_cmd(pat[0], ap);
              nxt_st.bc4 = chop;
              // New burst only once the previous one is in its last cycle or has finished
              if (st_ff.bcnt <= 3'h1) begin
                nxt_st.bcnt = burst_cyc(chop);
              end
            end
            default: nxt_st.cmd = DCD_ILLEGAL;
          endcase
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      st_ff <= '{cke_prev: 1'b1,
                 pwr:      DCD_ST_IDLE,
                 cmd:      DCD_NOP,
                 ba:       '0,
                 addr:     '0,
                 bc4:      1'b0,
                 bcnt:     3'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd        = st_ff.cmd;
  assign cmd_ba     = st_ff.ba;
  assign cmd_addr   = st_ff.addr;
  assign cmd_bc4    = st_ff.bc4;

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign burst_busy = st_ff.bcnt != 3'h0;
  assign in_pdn     = st_ff.pwr == DCD_ST_PDN;
  assign in_sref    = st_ff.pwr == DCD_ST_SREF;
  assign odt_ok     = st_ff.pwr != DCD_ST_SREF;

endmodule

//--- common/dcd_pkg.sv
// Package of the command decoder: encodings, widths, decoded opcodes.
// Assumes nothing beyond a SystemVerilog compiler.
package dcd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DCD_BA_W   = 3;
  localparam int DCD_ADDR_W = 16;

  // ----------------------------------------------------------------
  // Address bit positions
  // ----------------------------------------------------------------
  localparam int DCD_AP_BIT = 10;
  localparam int DCD_BC_BIT = 12;

  // ----------------------------------------------------------------
  // Command pin patterns {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] DCD_PAT_MRS = 4'h0;
  localparam logic [3:0] DCD_PAT_REF = 4'h1;
  localparam logic [3:0] DCD_PAT_PRE = 4'h2;
  localparam logic [3:0] DCD_PAT_ACT = 4'h3;
  localparam logic [3:0] DCD_PAT_WR  = 4'h4;
  localparam logic [3:0] DCD_PAT_RD  = 4'h5;
  localparam logic [3:0] DCD_PAT_ZQ  = 4'h6;
  localparam logic [3:0] DCD_PAT_NOP = 4'h7;

  // ----------------------------------------------------------------
  // Burst and timing counts
  // ----------------------------------------------------------------
  localparam int DCD_BL8_CYC = 4;   // Clock cycles of an 8-beat burst
  localparam int DCD_BC4_CYC = 2;   // Clock cycles of a chopped burst
  localparam int DCD_SRX_WR_NCK = 512;

  // ----------------------------------------------------------------
  // Decoded command
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DCD_NOP, DCD_DES, DCD_MRS, DCD_REF, DCD_SRE, DCD_SRX,
    DCD_PRE, DCD_PREA, DCD_ACT, DCD_WR, DCD_WRA, DCD_RD, DCD_RDA,
    DCD_PDE, DCD_PDX, DCD_ZQCL, DCD_ZQCS, DCD_ILLEGAL
  } dcd_cmd_t;

  typedef enum logic [1:0] {
    DCD_ST_IDLE, DCD_ST_PDN, DCD_ST_SREF
  } dcd_pwr_t;

endpackage

//--- common/dcd_if.sv
// Command and address pins between controller and decoder.
// Assumes both ends run on the same core_clk.
`timescale 1ns/1ps
interface dcd_if
  import dcd_pkg::*;
#(
  parameter int BA_W   = DCD_BA_W,
  parameter int ADDR_W = DCD_ADDR_W
);
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              odt;
  logic              reset_n;

  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
                output reset_n);
  modport dev  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
                input reset_n);
endinterface

//--- logic/dcd_ctrl.sv
// Controller end: turns one-cycle user requests into command pin levels.
// Assumes the device decodes on the same core_clk edge.
`timescale 1ns/1ps
module dcd_ctrl
  import dcd_pkg::*;
#(
  parameter int BA_W   = DCD_BA_W,
  parameter int ADDR_W = DCD_ADDR_W,
  parameter int SRX_WR_NCK = DCD_SRX_WR_NCK
) (
  input  wire logic              core_clk,  // Clock
  input  wire logic              rstn,      // Async reset, active low
  input  wire logic              req,       // Request pulse
  input  dcd_pkg::dcd_cmd_t      req_cmd,   // Requested command
  input  wire logic [BA_W-1:0]   req_ba,    // Bank address
  input  wire logic [ADDR_W-1:0] req_addr,  // Address
  input  wire logic              dev_rst,   // Reset the device
  output logic                   req_ready, // Request may be taken
  dcd_if.ctrl                    pins       // Command pins
);
  import dcd_pkg::*;

  typedef struct packed {
    logic              cke;
    logic [3:0]        pat;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic              rst_n;
    logic [9:0]        wcnt;
  } dcd_cst_t;

  dcd_cst_t st_ff;
  dcd_cst_t nxt_st;

  // ----------------------------------------------------------------
  // Encode
  // ----------------------------------------------------------------
  always_comb begin
    logic wr;
    wr     = req_cmd == DCD_WR || req_cmd == DCD_WRA;
    nxt_st = st_ff;
    nxt_st.pat   = DCD_PAT_NOP;
    nxt_st.rst_n = ~dev_rst;
    nxt_st.ba    = req_ba;
    nxt_st.addr  = req_addr;
    if (st_ff.wcnt != 10'h0) begin
      nxt_st.wcnt = st_ff.wcnt - 10'h1;
    end
    if (req && req_ready) begin
      case (req_cmd)
        DCD_MRS:  nxt_st.pat = DCD_PAT_MRS;
        DCD_REF:  nxt_st.pat = DCD_PAT_REF;
        DCD_SRE: begin
          nxt_st.pat = DCD_PAT_REF;
          nxt_st.cke = 1'b0;
        end
        DCD_SRX: begin
          nxt_st.cke  = 1'b1;
          nxt_st.wcnt = 10'(SRX_WR_NCK);
        end
        DCD_PDE:  nxt_st.cke = 1'b0;
        DCD_PDX:  nxt_st.cke = 1'b1;
        DCD_PRE, DCD_PREA: begin
          nxt_st.pat = DCD_PAT_PRE;
          nxt_st.addr[DCD_AP_BIT] = req_cmd == DCD_PREA;
        end
        DCD_ACT:  nxt_st.pat = DCD_PAT_ACT;
        DCD_WR, DCD_WRA, DCD_RD, DCD_RDA: begin
          nxt_st.pat = wr ? DCD_PAT_WR : DCD_PAT_RD;
          nxt_st.addr[DCD_AP_BIT] = req_cmd == DCD_WRA ||
                                    req_cmd == DCD_RDA;
        end
        DCD_ZQCL, DCD_ZQCS: begin
          nxt_st.pat = DCD_PAT_ZQ;
          nxt_st.addr[DCD_AP_BIT] = req_cmd == DCD_ZQCL;
        end
        DCD_DES:  nxt_st.pat = 4'h8;
        default:  nxt_st.pat = DCD_PAT_NOP;
      endcase
    end
  end

  // Writes held off for 512 clocks after self refresh exit
  always_comb begin
    req_ready = 1'b1;
    if (st_ff.wcnt != 10'h0 &&
        (req_cmd == DCD_WR || req_cmd == DCD_WRA)) begin
      req_ready = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{cke: 1'b1, pat: DCD_PAT_NOP, ba: '0, addr: '0,
                 rst_n: 1'b0, wcnt: 10'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins.cke     = st_ff.cke;
  assign pins.cs_n    = st_ff.pat[3];
  assign pins.ras_n   = st_ff.pat[2];
  assign pins.cas_n   = st_ff.pat[1];
  assign pins.we_n    = st_ff.pat[0];
  assign pins.ba      = st_ff.ba;
  assign pins.addr    = st_ff.addr;
  // Termination on with write commands only
  assign pins.odt     = st_ff.pat == DCD_PAT_WR;
  assign pins.reset_n = st_ff.rst_n;

endmodule

//--- dv/dcd_monitor.sv
// Checker on the command pins between controller and decoder.
// Assumes one clock domain; sees only the pin levels of dcd_if.
`timescale 1ns/1ps
module dcd_monitor
  import dcd_pkg::*;
#(
  parameter int SRX_WR_NCK = DCD_SRX_WR_NCK
) (
  input wire logic core_clk, // Clock
  input wire logic rstn,     // Async reset, active low
  input wire logic cke,      // Clock enable
  input wire logic cs_n,     // Chip select
  input wire logic ras_n,    // Row strobe
  input wire logic cas_n,    // Column strobe
  input wire logic we_n,     // Write strobe
  input wire logic reset_n   // Device reset
);
  logic [3:0] pat;
  logic       cke_ff;
  logic       sref_ff;
  int         cnt_ff;

  assign pat = {cs_n, ras_n, cas_n, we_n};

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // Self refresh state and cycles since its exit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cke_ff  <= 1'b1;
      sref_ff <= 1'b0;
      cnt_ff  <= SRX_WR_NCK;
    end else begin
      cke_ff <= cke;
      if (cke_ff && !cke && pat == DCD_PAT_REF) begin
        sref_ff <= 1'b1;
      end else if (sref_ff && cke) begin
        sref_ff <= 1'b0;
        cnt_ff  <= 0;
      end else if (cnt_ff < SRX_WR_NCK) begin
        cnt_ff <= cnt_ff + 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_cke_down;
    $fell(cke);
  endsequence
  sequence s_sref_exit;
    sref_ff && cke;
  endsequence

  a_fall_idle_cmd: assert property (s_cke_down |->
    cs_n || pat == DCD_PAT_NOP || pat == DCD_PAT_REF)
    else $error("cke fell with a command other than NOP or refresh");
  a_rise_idle_cmd: assert property ($rose(cke) |->
    cs_n || pat == DCD_PAT_NOP)
    else $error("cke rose with a command other than NOP");
  a_sref_exit_nop: assert property (s_sref_exit |->
    cs_n || pat == DCD_PAT_NOP)
    else $error("self refresh left without NOP or deselect");
  a_mrs_cke_high: assert property (pat == DCD_PAT_MRS |->
    cke && $past(cke))
    else $error("mode register set without cke high twice");
  a_ref_cke_high: assert property (pat == DCD_PAT_REF && cke |->
    $past(cke))
    else $error("refresh with cke low in previous cycle");
  a_low_cke_quiet: assert property (!cke && !$fell(cke) |->
    cs_n || pat == DCD_PAT_NOP)
    else $error("command issued while cke held low");
  a_srx_write_gap: assert property (pat == DCD_PAT_WR |->
    cnt_ff >= SRX_WR_NCK - 1)
    else $error("write too soon after self refresh exit");
  a_reset_held_hi: assert property (!cs_n && pat != DCD_PAT_NOP |->
    reset_n)
    else $error("command issued while device reset is low");
endmodule

//--- dv/ddr3_command_decoder_tb.sv
// Self-checking bench: controller and decoder joined by dcd_if.
// Assumes a 40 MHz core_clk and a shortened self refresh write wait.
`timescale 1ns/1ps
module ddr3_command_decoder_tb;
  import dcd_pkg::*;
  typedef struct packed {
    dcd_cmd_t c; logic [2:0] b; logic [15:0] a; logic k; logic [1:0] m;
  } dcd_exp_t;
  logic core_clk, rstn, req, dev_rst, req_ready, fixed_bl, fixed_bc4;
  logic cmd_bc4, burst_busy, in_pdn, in_sref, odt_ok;
  logic [2:0]  req_ba, cmd_ba;
  logic [15:0] req_addr, cmd_addr;
  dcd_cmd_t    req_cmd, cmd;
  dcd_exp_t    expq[$];
  dcd_exp_t    got;
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  dcd_cmd_t    ops[13] = '{DCD_MRS, DCD_REF, DCD_ACT, DCD_PRE, DCD_PREA,
    DCD_WR, DCD_WRA, DCD_RD, DCD_RDA, DCD_ZQCL, DCD_ZQCS, DCD_DES, DCD_RD};

  dcd_if pins_if ();
  dcd_ctrl #(.SRX_WR_NCK(8)) dcd_ctrl_i (.core_clk(core_clk), .rstn(rstn),
    .req(req), .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
    .dev_rst(dev_rst), .req_ready(req_ready), .pins(pins_if));
  dcd_device dcd_device_i (.core_clk(core_clk), .rstn(rstn), .pins(pins_if),
    .fixed_bl(fixed_bl), .fixed_bc4(fixed_bc4), .cmd(cmd), .cmd_ba(cmd_ba),
    .cmd_addr(cmd_addr), .cmd_bc4(cmd_bc4), .burst_busy(burst_busy),
    .in_pdn(in_pdn), .in_sref(in_sref), .odt_ok(odt_ok));
  dcd_monitor #(.SRX_WR_NCK(8)) dcd_monitor_i (.core_clk(core_clk),
    .rstn(rstn), .cke(pins_if.cke), .cs_n(pins_if.cs_n),
    .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n),
    .reset_n(pins_if.reset_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic gap(int k);
    req = 1'b0;
    repeat (k) @(negedge core_clk);
  endtask

  // Drive one request and note what the decoder must report
  task automatic issue(dcd_cmd_t c, logic [2:0] b, logic [15:0] a);
    dcd_exp_t e;
    int w;
    w = 0;
    if (!req_ready) begin
      req = 1'b0;
      while (!req_ready && w < 2000) begin
        @(negedge core_clk);
        w++;
      end
      if (w >= 2000) begin
        err_total++;
        test_done();
      end
    end
    e.c = c;
    e.b = b;
    e.a = a;
    if (c inside {DCD_PREA, DCD_WRA, DCD_RDA, DCD_ZQCL}) e.a[DCD_AP_BIT] = 1'b1;
    if (c inside {DCD_PRE, DCD_WR, DCD_RD, DCD_ZQCS}) e.a[DCD_AP_BIT] = 1'b0;
    e.k = fixed_bl ? fixed_bc4 : !a[DCD_BC_BIT];
    e.m = (c inside {DCD_WR, DCD_WRA, DCD_RD, DCD_RDA}) ? 2'h2 :
          (c inside {DCD_SRE, DCD_SRX, DCD_PDE, DCD_PDX, DCD_DES}) ? 2'h0 : 2'h1;
    expq.push_back(e);
    req = 1'b1;
    req_cmd = c;
    req_ba = b;
    req_addr = a;
    @(negedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(negedge core_clk) begin
    if (rstn && cmd !== DCD_NOP) begin
      if (expq.size() == 0) chk(cmd, DCD_NOP);
      else begin
        got = expq.pop_front();
        chk(cmd, got.c);
        if (got.m != 0) chk({cmd_ba, cmd_addr}, {got.b, got.a});
        if (got.m == 2) chk(cmd_bc4, got.k);
        if (got.c == DCD_SRE) chk({in_sref, odt_ok}, 2'h2);
        if (got.c == DCD_PDE) chk(in_pdn, 1'b1);
        if (got.c inside {DCD_SRX, DCD_PDX}) begin
          chk({in_sref, in_pdn, odt_ok}, 3'h1);
        end
        if (got.c == DCD_ILLEGAL) chk(in_sref, 1'b0);
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    #1000000;
    err_total++;
    test_done();
  end

  initial begin
    {rstn, req, req_ba, req_addr, fixed_bl, fixed_bc4} = '0;
    req_cmd = DCD_NOP;
    dev_rst = 1'b1;
    void'($urandom(32'h18ee));
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    gap(4);
    dev_rst = 1'b0;
    gap(4);
    for (int p = 0; p < 2; p++) begin
      fixed_bl = p[0];
      fixed_bc4 = 1'($urandom);
      foreach (ops[i]) issue(ops[i], 3'($urandom), 16'($urandom));
      gap(8);
    end
    fixed_bl = 1'b0;
    issue(DCD_PDE, 3'h0, 16'h0);
    gap(4);
    issue(DCD_PDX, 3'h0, 16'h0);
    gap(4);
    issue(DCD_SRE, 3'h0, 16'h0);
    gap(6);
    issue(DCD_SRX, 3'h0, 16'h0);
    req = 1'b0;
    req_cmd = DCD_WR;
    @(negedge core_clk);
    chk(req_ready, 1'b0);
    for (int b = 0; b < 2; b++) begin
      issue(DCD_WR, 3'h1, {3'h0, b[0], 12'h0});
      gap(1);
      n = 0;
      repeat (12) begin
        n += int'(burst_busy === 1'b1);
        @(negedge core_clk);
      end
      chk(n, b ? DCD_BL8_CYC : DCD_BC4_CYC);
    end
    // Device reset pin clears a running burst
    issue(DCD_RD, 3'h3, 16'h1000);
    gap(1);
    dev_rst = 1'b1;
    gap(1);
    chk(burst_busy, 1'b0);
    dev_rst = 1'b0;
    gap(2);
    // Self refresh entry during a burst is refused
    issue(DCD_RD, 3'h2, 16'h1000);
    issue(DCD_SRE, 3'h0, 16'h0);
    expq[expq.size()-1].c = DCD_ILLEGAL;
    expq.push_back('{DCD_PDE, 3'h0, 16'h0, 1'b0, 2'h0});
    gap(3);
    issue(DCD_PDX, 3'h0, 16'h0);
    gap(10);
    chk(expq.size(), 0);
    test_done();
  end
endmodule
